// [logic/cvc_defs.vh]
`ifndef CVC_DEFS_VH
`define CVC_DEFS_VH

// Serial frame layout
`define CVC_FRAME_BITS 32
`define CVC_CNT_W 5
`define CVC_CNT_LAST 5'h1F
`define CVC_HDR_MSB 31
`define CVC_HDR_LSB 20
`define CVC_HDR_PATTERN 12'h001
`define CVC_ADR_MSB 19
`define CVC_ADR_LSB 16
`define CVC_DAT_MSB 15

// Register addresses
`define CVC_ADDR_CONFIG 4'h1
`define CVC_ADDR_OFFSET 4'h2
`define CVC_ADDR_FSCALE 4'h3

// Configuration register fields and reset values
`define CVC_CFG_DCS 12
`define CVC_CFG_DCP 11
`define CVC_CFG_NDE 10
`define CVC_CFG_OV 9
`define CVC_CFG_OE 8
`define CVC_CFG_RESET 16'hB2FF
`define CVC_OFS_RESET 16'h0000
`define CVC_FS_RESET 16'h8000

// Timing counts in input clock cycles, pipeline fill in words
`define CVC_TRIM_CYCLES 8'h50
`define CVC_POR_SHORT 32'h0200_0000
`define CVC_POR_LONG 32'h8000_0000
`define CVC_CAL_CYCLES 32'h0000_4000
`define CVC_PIPE_WORDS 4'h7
`define CVC_STRAP_WAIT 3'h5

// Synchroniser bit positions
`define CVC_SYNC_W 11
`define CVC_SYNC_RST 11'h002
`define CVC_S_SCLK 0
`define CVC_S_SEL 1
`define CVC_S_SDI 2
`define CVC_S_PD 3
`define CVC_S_TRIM 4
`define CVC_S_EDGE 5
`define CVC_S_EFLT 6
`define CVC_S_LVL 7
`define CVC_S_CDLY 8
`define CVC_S_RNG 9
`define CVC_S_RFLT 10

`endif

// [logic/cvc_sync.v]
`timescale 1ns/100ps
module cvc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire ref_clk,
  input wire srst,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] ff1_q;
  reg [W-1:0] ff2_q;
  reg [W-1:0] ff3_q;

  // A change is taken only once stages two and three agree
  always @(posedge ref_clk) begin
    if (srst) begin
      ff1_q <= RST_VAL;
      ff2_q <= RST_VAL;
      ff3_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      ff1_q <= async_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      sync_o <= (ff2_q & ff3_q) | (sync_o & (ff2_q ^ ff3_q));
    end
  end

endmodule

// [logic/cvc_ctrl.v]
// How it works
// - Single rate: strobe clock runs at each bus word rate.
// - Double rate: strobe at half word rate, words launched on both edges.
// - Normal mode: floating edge pin selects double rate.
// - Normal mode: level select high gives high drive, low gives low drive.
// - Active while power_down low, powered down while high.
// - Power-down floats data outputs; strobe and range flag pulled low.
// - After power-down the pipeline is invalid until refilled.
// - Power-down waits until a running calibration finishes.
// - Power-down at power-up holds off the power-up calibration.
// - Manual calibration requests are ignored in power-down.
// - Normal mode: aligned phase; extended: clocking from config bits.
// - Cal delay from pin in normal mode, always short in extended.
// - Extended mode: full scale from full-scale register.
// - Extended mode: offset from offset register; none in normal mode.
// - Extended defaults: double rate, aligned, normal level, short delay, nominal.
// - Serial port answers only in extended mode.
// - Serial data sampled on rising serial clock edges.
// - Frame: 32 bits MSB first, 12 header, 4 address, 16 data.
// - Header is eleven zeros then one.
// - Next frame may start on clock 33 without releasing select.
// - Write-only port to three registers, no readback.
// - Address 1 config, 2 offset, 3 full scale, others reserved.
// - Registers have no effect in normal mode.
// - Manual calibration needs 80 cycles low then 80 high.
// - Calibration active flag high during any calibration.
`timescale 1ns/100ps
`include "cvc_defs.vh"
module cvc_ctrl #(
  parameter DW = 8,
  parameter [31:0] POR_SHORT = `CVC_POR_SHORT,
  parameter [31:0] POR_LONG = `CVC_POR_LONG,
  parameter [31:0] CAL_CYCLES = `CVC_CAL_CYCLES
) (
  input wire ref_clk,
  input wire srst,
  input wire serial_shift_clock,
  input wire serial_select_n,
  input wire serial_input_line,
  input wire power_down,
  input wire trim_request,
  input wire output_edge_pin,
  input wire output_edge_float,
  input wire output_level_select,
  input wire cal_delay_select,
  input wire range_or_ext_ctrl_select,
  input wire range_pin_float,
  input wire [DW-1:0] sample_data,
  input wire sample_over_range,
  output reg [DW-1:0] bus_a_data_q,
  output reg [DW-1:0] bus_b_data_q,
  output reg data_oe_q,
  output reg data_valid_q,
  output reg output_strobe_clock_q,
  output reg out_of_range_q,
  output reg weak_pull_down_q,
  output reg drive_level_high_q,
  output reg duty_stabilizer_q,
  output reg ext_mode_q,
  output reg range_high_q,
  output reg [15:0] offset_code_q,
  output reg [15:0] full_scale_code_q,
  output reg calibration_active_q,
  output reg powered_down_q
);

  localparam ST_WAIT = 3'b001;
  localparam ST_IDLE = 3'b010;
  localparam ST_RUN = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire [`CVC_SYNC_W-1:0] pins_s;

  cvc_sync #(
    .W(`CVC_SYNC_W),
    .RST_VAL(`CVC_SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_i({range_pin_float, range_or_ext_ctrl_select, cal_delay_select,
              output_level_select, output_edge_float, output_edge_pin,
              trim_request, power_down, serial_input_line,
              serial_select_n, serial_shift_clock}),
    .sync_o(pins_s)
  );

  wire sclk_s = pins_s[`CVC_S_SCLK];
  wire sel_n_s = pins_s[`CVC_S_SEL];
  wire sdi_s = pins_s[`CVC_S_SDI];
  wire pd_s = pins_s[`CVC_S_PD];
  wire trim_s = pins_s[`CVC_S_TRIM];

  ////////////////////////////////////////////////////////////////////////
  // Mode strap, caught once after reset release

  reg [2:0] strap_cnt_q;
  reg ext_q;

  // Strap read only once the synchroniser has filled; later changes ignored
  always @(posedge ref_clk) begin
    if (srst) begin
      strap_cnt_q <= 3'h0;
      ext_q <= 1'b0;
    end else if (strap_cnt_q != `CVC_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      ext_q <= pins_s[`CVC_S_RFLT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial port

  reg sclk_prev_q;
  reg [`CVC_CNT_W-1:0] bit_cnt_q;
  reg [`CVC_FRAME_BITS-2:0] shift_q;
  reg [15:0] cfg_q;
  reg [15:0] ofs_q;
  reg [15:0] fs_q;

  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire [`CVC_FRAME_BITS-1:0] frame = {shift_q, sdi_s};
  wire [3:0] frame_addr = frame[`CVC_ADR_MSB:`CVC_ADR_LSB];
  wire [15:0] frame_data = frame[`CVC_DAT_MSB:0];
  wire hdr_ok = (frame[`CVC_HDR_MSB:`CVC_HDR_LSB] == `CVC_HDR_PATTERN);
  wire frame_end = sclk_rise && (bit_cnt_q == `CVC_CNT_LAST);

  always @(posedge ref_clk) begin
    if (srst) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= {`CVC_CNT_W{1'b0}};
      shift_q <= {(`CVC_FRAME_BITS-1){1'b0}};
    end else begin
      sclk_prev_q <= sclk_s;
      if (!ext_q || sel_n_s) begin
        bit_cnt_q <= {`CVC_CNT_W{1'b0}};
      end else if (sclk_rise) begin
        shift_q <= frame[`CVC_FRAME_BITS-2:0];
        // Wraps to zero so a new frame starts on clock 33
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end

  // Write-only; nothing of these is ever sent back
  always @(posedge ref_clk) begin
    if (srst) begin
      cfg_q <= `CVC_CFG_RESET;
      ofs_q <= `CVC_OFS_RESET;
      fs_q <= `CVC_FS_RESET;
    end else if (ext_q && !sel_n_s && frame_end && hdr_ok) begin
      case (frame_addr)
        `CVC_ADDR_CONFIG: begin
          cfg_q <= frame_data;
        end
        `CVC_ADDR_OFFSET: begin
          ofs_q <= frame_data;
        end
        `CVC_ADDR_FSCALE: begin
          fs_q <= frame_data;
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective controls, pins or fixed values in normal mode, register or fixed values in extended mode

  wire ddr_en = ext_q ? ~cfg_q[`CVC_CFG_NDE] : pins_s[`CVC_S_EFLT];
  wire edge_rise = ext_q ? cfg_q[`CVC_CFG_OE] : pins_s[`CVC_S_EDGE];
  wire phase90 = ext_q & cfg_q[`CVC_CFG_DCP];
  wire level_hi = ext_q ? cfg_q[`CVC_CFG_OV] : pins_s[`CVC_S_LVL];
  wire long_dly = ~ext_q & pins_s[`CVC_S_CDLY];

  always @(posedge ref_clk) begin
    if (srst) begin
      drive_level_high_q <= 1'b0;
      duty_stabilizer_q <= 1'b1;
      ext_mode_q <= 1'b0;
      range_high_q <= 1'b0;
      offset_code_q <= `CVC_OFS_RESET;
      full_scale_code_q <= `CVC_FS_RESET;
    end else begin
      drive_level_high_q <= level_hi;
      duty_stabilizer_q <= ext_q ? cfg_q[`CVC_CFG_DCS] : 1'b1;
      ext_mode_q <= ext_q;
      range_high_q <= ~ext_q & pins_s[`CVC_S_RNG];
      // Registers are masked in normal mode
      offset_code_q <= ext_q ? ofs_q : `CVC_OFS_RESET;
      full_scale_code_q <= ext_q ? fs_q : `CVC_FS_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Manual calibration request detector

  reg [7:0] lo_cnt_q;
  reg [7:0] hi_cnt_q;
  reg trim_req_q;

  always @(posedge ref_clk) begin
    if (srst || powered_down_q) begin
      // Counts are dropped so no request survives power-down
      lo_cnt_q <= 8'h00;
      hi_cnt_q <= 8'h00;
      trim_req_q <= 1'b0;
    end else if (!trim_s) begin
      hi_cnt_q <= 8'h00;
      trim_req_q <= 1'b0;
      if (lo_cnt_q != `CVC_TRIM_CYCLES) begin
        lo_cnt_q <= lo_cnt_q + 8'h01;
      end
    end else if (lo_cnt_q == `CVC_TRIM_CYCLES) begin
      if (hi_cnt_q == `CVC_TRIM_CYCLES - 8'h01) begin
        trim_req_q <= 1'b1;
        lo_cnt_q <= 8'h00;
        hi_cnt_q <= 8'h00;
      end else begin
        hi_cnt_q <= hi_cnt_q + 8'h01;
      end
    end else begin
      trim_req_q <= 1'b0;
      hi_cnt_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration sequencer and power-down

  reg [2:0] state_q;
  reg [31:0] cnt_q;
  wire [31:0] por_len = long_dly ? POR_LONG : POR_SHORT;

  always @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_WAIT;
      cnt_q <= 32'h0000_0000;
      calibration_active_q <= 1'b0;
    end else begin
      case (state_q)
        ST_WAIT: begin
          // Delay counter is frozen while power-down is held
          if (!pd_s) begin
            if (cnt_q >= por_len - 32'h0000_0001) begin
              state_q <= ST_RUN;
              cnt_q <= 32'h0000_0000;
              calibration_active_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 32'h0000_0001;
            end
          end
        end
        ST_IDLE: begin
          if (trim_req_q && !pd_s && !powered_down_q) begin
            state_q <= ST_RUN;
            cnt_q <= 32'h0000_0000;
            calibration_active_q <= 1'b1;
          end
        end
        ST_RUN: begin
          if (cnt_q >= CAL_CYCLES - 32'h0000_0001) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0000_0000;
            calibration_active_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= 32'h0000_0000;
          calibration_active_q <= 1'b0;
        end
      endcase
    end
  end

  // Entry into power-down waits for a running calibration
  wire pd_next = pd_s & (state_q != ST_RUN);

  always @(posedge ref_clk) begin
    if (srst) begin
      powered_down_q <= 1'b0;
    end else begin
      powered_down_q <= pd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output demux and strobe clock

  reg [1:0] ph_q;
  reg [DW-1:0] even_q;
  reg even_or_q;
  reg [3:0] fill_q;
  wire [1:0] ph_d = ph_q + 2'b01;
  wire word_load = ph_q[0];
  reg strobe_d;

  always @* begin
    if (ddr_en) begin
      // Half the word rate; data toggles on both strobe edges
      strobe_d = phase90 ? (ph_d[1] ^ ph_d[0]) : ph_d[1];
    end else begin
      // One strobe period per word on each bus
      strobe_d = edge_rise ? ~ph_d[0] : ph_d[0];
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      ph_q <= 2'b00;
      even_q <= {DW{1'b0}};
      even_or_q <= 1'b0;
      bus_a_data_q <= {DW{1'b0}};
      bus_b_data_q <= {DW{1'b0}};
      out_of_range_q <= 1'b0;
      output_strobe_clock_q <= 1'b0;
      data_oe_q <= 1'b0;
      weak_pull_down_q <= 1'b0;
      data_valid_q <= 1'b0;
      fill_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
      data_oe_q <= ~pd_next;
      weak_pull_down_q <= pd_next;
      if (!ph_q[0]) begin
        even_q <= sample_data;
        even_or_q <= sample_over_range;
      end
      if (pd_next) begin
        // Strobe and range flag idle low under the weak pull
        output_strobe_clock_q <= 1'b0;
        out_of_range_q <= 1'b0;
        fill_q <= 4'h0;
        data_valid_q <= 1'b0;
      end else begin
        output_strobe_clock_q <= strobe_d;
        if (word_load) begin
          bus_a_data_q <= even_q;
          bus_b_data_q <= sample_data;
          out_of_range_q <= even_or_q | sample_over_range;
          // Stale words flushed before valid returns
          if (fill_q != `CVC_PIPE_WORDS) begin
            fill_q <= fill_q + 4'h1;
          end else begin
            data_valid_q <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// [tb/cvc_ctrl_monitor.sv]
`timescale 1ns/100ps
module cvc_ctrl_monitor #(
  parameter DW = 8,
  parameter [31:0] CAL_CYCLES = 32'h0000_4000
) (
  input wire ref_clk,
  input wire srst,
  input wire output_level_select,
  input wire range_or_ext_ctrl_select,
  input wire [DW-1:0] sample_data,
  input wire [DW-1:0] bus_a_data_q,
  input wire [DW-1:0] bus_b_data_q,
  input wire duty_stabilizer_q,
  input wire range_high_q,
  input wire data_oe_q,
  input wire data_valid_q,
  input wire output_strobe_clock_q,
  input wire out_of_range_q,
  input wire weak_pull_down_q,
  input wire drive_level_high_q,
  input wire ext_mode_q,
  input wire [15:0] offset_code_q,
  input wire [15:0] full_scale_code_q,
  input wire calibration_active_q,
  input wire powered_down_q
);
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Counts high cycles of the flag so its length is checked exactly
  reg [31:0] cal_run_q;
  always @(posedge ref_clk) begin
    if (srst || !calibration_active_q)
      cal_run_q <= 32'h0000_0000;
    else
      cal_run_q <= cal_run_q + 32'h0000_0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  pd_outputs_a: assert property (powered_down_q [*3] |-> !data_oe_q && weak_pull_down_q
    && !output_strobe_clock_q && !out_of_range_q) else $error("pd outputs wrong");
  cal_defer_a: assert property (calibration_active_q |-> !$rose(powered_down_q))
    else $error("pd entered during cal");
  pd_no_cal_a: assert property (powered_down_q |=> !$rose(calibration_active_q))
    else $error("cal began in pd");
  cal_length_a: assert property ($fell(calibration_active_q) |-> cal_run_q == CAL_CYCLES)
    else $error("cal length wrong");
  norm_regs_a: assert property (!ext_mode_q |-> offset_code_q == 16'h0000
    && full_scale_code_q == 16'h8000) else $error("regs act in normal mode");
  level_high_a: assert property ((!ext_mode_q && output_level_select) [*6] |-> drive_level_high_q)
    else $error("level high missed");
  level_low_a: assert property ((!ext_mode_q && !output_level_select) [*6] |-> !drive_level_high_q)
    else $error("level low missed");
  pipe_refill_a: assert property ($fell(powered_down_q) |-> !data_valid_q [*8])
    else $error("valid too early");
  word_pair_a: assert property ($changed({bus_a_data_q, bus_b_data_q}) |->
    bus_a_data_q == $past(sample_data, 2) && bus_b_data_q == $past(sample_data))
    else $error("bus word pair wrong");
  duty_norm_a: assert property (!ext_mode_q |-> duty_stabilizer_q)
    else $error("duty bit acts in normal mode");
  range_ext_a: assert property (ext_mode_q |-> !range_high_q)
    else $error("range pin acts in extended mode");
  range_pin_a: assert property ((!ext_mode_q && range_or_ext_ctrl_select) [*6] |-> range_high_q)
    else $error("range high missed");
  cov_ext: cover property ($rose(ext_mode_q));
  cov_cal: cover property ($rose(calibration_active_q));
  cov_pd: cover property ($rose(powered_down_q));
  cov_vld: cover property ($rose(data_valid_q));
endmodule

// [tb/cvc_host.sv]
`timescale 1ns/100ps
module cvc_host (
  output reg serial_shift_clock,
  output reg serial_select_n,
  output reg serial_input_line
);
  integer i;
  initial begin
    serial_shift_clock = 1'b0;
    serial_select_n = 1'b1;
    serial_input_line = 1'b0;
  end
  // Clock stands low between frames; data inverts once released
  task send(input [31:0] frame, input last);
    begin
      serial_select_n = 1'b0;
      for (i = 31; i >= 0; i = i - 1) begin
        serial_input_line = frame[i];
        #62.5 serial_shift_clock = 1'b1;
        #62.5 serial_shift_clock = 1'b0;
      end
      // Select stays low between chained frames
      if (last) begin
        serial_select_n = 1'b1;
        serial_input_line = ~serial_input_line;
        #125;
      end
    end
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  localparam [31:0] POR_S = 32'h0000_0040;
  localparam [31:0] POR_L = 32'h0000_0080;
  localparam [31:0] CAL_N = 32'h0000_0020;
  localparam int F_PD = 0, F_OE = 1, F_PULL = 2, F_OR = 3, F_STB = 4, F_CAL = 5, F_LVL = 6, F_VLD = 7;
  localparam int S_OFS = 8, S_FS = 9, S_PER = 10, S_EXT = 11;
  reg ref_clk;
  reg srst = 1'b1;
  reg power_down = 1'b0;
  reg trim_request = 1'b1;
  reg output_edge_float = 1'b1;
  reg output_level_select = 1'b1;
  reg cal_delay_select = 1'b1;
  reg range_pin_float = 1'b0;
  reg [7:0] sample_data = 8'h00;
  reg sample_over_range = 1'b0;
  wire sclk, sel_n, sdi, oe, vld, stb, oor, pull, lvl, cal, pd, ext;
  wire [15:0] ofs, fs;
  wire [7:0] flags = {vld, lvl, cal, stb, oor, pull, oe, pd};
  integer seed = 32'h4631DCE3;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int q_sel[$];
  logic [15:0] q_exp[$];
  int c_sel;
  logic [15:0] c_exp;
  logic [15:0] r_ofs, r_fs;
  reg stb_prev_q = 1'b0;
  reg [15:0] pc_q = 16'h0000;
  reg [15:0] per_q = 16'h0000;
  cvc_host u_host (.serial_shift_clock(sclk), .serial_select_n(sel_n), .serial_input_line(sdi));
  cvc_ctrl #(.DW(8), .POR_SHORT(POR_S), .POR_LONG(POR_L), .CAL_CYCLES(CAL_N)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .serial_shift_clock(sclk), .serial_select_n(sel_n),
    .serial_input_line(sdi), .power_down(power_down), .trim_request(trim_request),
    .output_edge_pin(1'b1), .output_edge_float(output_edge_float), .output_level_select(output_level_select),
    .cal_delay_select(cal_delay_select), .range_or_ext_ctrl_select(1'b1), .range_pin_float(range_pin_float),
    .sample_data(sample_data), .sample_over_range(sample_over_range), .bus_a_data_q(), .bus_b_data_q(),
    .data_oe_q(oe), .data_valid_q(vld), .output_strobe_clock_q(stb), .out_of_range_q(oor),
    .weak_pull_down_q(pull), .drive_level_high_q(lvl), .duty_stabilizer_q(), .ext_mode_q(ext),
    .range_high_q(), .offset_code_q(ofs), .full_scale_code_q(fs), .calibration_active_q(cal),
    .powered_down_q(pd));
  ////////////////////////////////////////////////////////////////////////////
  function logic [15:0] obs(input int s);
    if (s < 8)
      obs = {15'h0000, flags[s]};
    else if (s == S_OFS)
      obs = ofs;
    else if (s == S_FS)
      obs = fs;
    else if (s == S_EXT)
      obs = {15'h0000, ext};
    else
      obs = per_q;
  endfunction
  task note(input int s, input [15:0] e);
    q_sel.push_back(s);
    q_exp.push_back(e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait; a timeout shows up as a mismatch
  task wait_for(input int s, input [15:0] e, input int lim);
    int k;
    k = 0;
    while (obs(s) !== e && k < lim) begin
      cyc(1);
      k = k + 1;
    end
    note(s, e);
  endtask
  task trim_pulse;
    trim_request = 1'b0;
    cyc(100);
    trim_request = 1'b1;
    cyc(84);
  endtask
  task final_report;
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    #1;
    {sample_over_range, sample_data} <= 9'($random(seed));
  end
  // Strobe period in ref_clk cycles, rise to rise
  always @(posedge ref_clk) begin
    stb_prev_q <= stb;
    if (stb && !stb_prev_q) begin
      per_q <= pc_q + 16'h0001;
      pc_q <= 16'h0000;
    end else begin
      pc_q <= pc_q + 16'h0001;
    end
  end
  always @(negedge ref_clk) begin
    while (q_sel.size() > 0) begin
      c_sel = q_sel.pop_front();
      c_exp = q_exp.pop_front();
      compares = compares + 1;
      if (obs(c_sel) !== c_exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: got %h expected %h", $time, obs(c_sel), c_exp);
      end
    end
  end
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  initial begin
    cyc(5);
    srst = 1'b0;
    // Long delay pin set; a short delay would already be calibrating here
    cyc(POR_S + 16);
    note(F_CAL, 16'h0000);
    wait_for(F_CAL, 16'h0001, POR_L);
    wait_for(F_CAL, 16'h0000, CAL_N + 8);
    cyc(20);
    note(S_PER, 16'h0004);
    output_edge_float = 1'b0;
    cyc(20);
    note(S_PER, 16'h0002);
    output_level_select = 1'b0;
    cyc(10);
    note(F_LVL, 16'h0000);
    output_level_select = 1'b1;
    cyc(10);
    note(F_LVL, 16'h0001);
    u_host.send({12'h001, 4'h2, 16'($random(seed))}, 1'b0);
    u_host.send({12'h001, 4'h3, 16'($random(seed))}, 1'b1);
    cyc(20);
    note(S_OFS, 16'h0000);
    note(S_FS, 16'h8000);
    note(S_EXT, 16'h0000);
    trim_pulse;
    wait_for(F_CAL, 16'h0001, 20);
    power_down = 1'b1;
    cyc(8);
    note(F_PD, 16'h0000);
    wait_for(F_CAL, 16'h0000, CAL_N + 8);
    wait_for(F_PD, 16'h0001, 10);
    cyc(4);
    note(F_OE, 16'h0000);
    note(F_PULL, 16'h0001);
    note(F_STB, 16'h0000);
    note(F_OR, 16'h0000);
    trim_pulse;
    cyc(20);
    note(F_CAL, 16'h0000);
    power_down = 1'b0;
    cyc(8);
    note(F_VLD, 16'h0000);
    wait_for(F_VLD, 16'h0001, 40);
    note(F_OE, 16'h0001);
    srst = 1'b1;
    power_down = 1'b1;
    // Mode strap is only caught in the first cycles after reset release
    range_pin_float = 1'b1;
    output_level_select = 1'b0;
    cyc(5);
    srst = 1'b0;
    cyc(POR_S + CAL_N + 40);
    note(F_CAL, 16'h0000);
    power_down = 1'b0;
    wait_for(F_CAL, 16'h0001, POR_S + 40);
    wait_for(F_CAL, 16'h0000, CAL_N + 8);
    cyc(20);
    note(S_EXT, 16'h0001);
    note(S_PER, 16'h0004);
    note(F_LVL, 16'h0001);
    note(S_OFS, 16'h0000);
    note(S_FS, 16'h8000);
    r_ofs = 16'($random(seed));
    r_fs = 16'($random(seed));
    // No serial traffic while calibrating
    u_host.send({12'h001, 4'h2, r_ofs}, 1'b0);
    u_host.send({12'h001, 4'h3, r_fs}, 1'b1);
    cyc(20);
    note(S_OFS, r_ofs);
    note(S_FS, r_fs);
    u_host.send({12'h003, 4'h2, ~r_ofs}, 1'b1);
    u_host.send({12'h001, 4'h5, ~r_fs}, 1'b1);
    cyc(20);
    note(S_OFS, r_ofs);
    note(S_FS, r_fs);
    u_host.send({12'h001, 4'h1, 16'hB4FF}, 1'b1);
    cyc(20);
    note(S_PER, 16'h0002);
    note(F_LVL, 16'h0000);
    cyc(2);
    final_report;
  end
endmodule
bind cvc_ctrl cvc_ctrl_monitor #(.DW(DW), .CAL_CYCLES(CAL_CYCLES)) u_mon (.ref_clk(ref_clk), .srst(srst),
  .output_level_select(output_level_select), .range_or_ext_ctrl_select(range_or_ext_ctrl_select),
  .sample_data(sample_data), .bus_a_data_q(bus_a_data_q), .bus_b_data_q(bus_b_data_q),
  .duty_stabilizer_q(duty_stabilizer_q), .range_high_q(range_high_q),
  .data_oe_q(data_oe_q), .data_valid_q(data_valid_q),
  .output_strobe_clock_q(output_strobe_clock_q), .out_of_range_q(out_of_range_q),
  .weak_pull_down_q(weak_pull_down_q), .drive_level_high_q(drive_level_high_q), .ext_mode_q(ext_mode_q),
  .offset_code_q(offset_code_q), .full_scale_code_q(full_scale_code_q),
  .calibration_active_q(calibration_active_q), .powered_down_q(powered_down_q));
